// ### nsc_pkg.sv
// package: register indices, field positions and reset values of the status/control bank
// ==========================================================================
// How it works
// - receive frame completion sets receive-done flag
// - transmit completion sets transmit-done flag, mask 9
// - init block read sets init-done flag, mask 8
// - event flags write-one-clear, reset or halt clear
// - summary flag ORs unmasked flags except collision, read only
// - interrupt output needs master enable and summary
// - master enable follows written bit, halt clears
// - poll demand kicks ring; dropped when transmit off
// - poll demand write-one-set, cleared by descriptor fetch
// - halt stops activity and wins simultaneous writes
// - halt set by write or reset, cleared by run/init
// - run enables traffic; init completes before run
// - init request starts block read, stays set
// - run and init write-one-set, halt clears them
// - low address write also loads low shadow
// - high address holds bits 23:16, loads shadow
// - address registers writable only halted or suspended
// - mask bits block flags, reset clears masks
// - underflow stops transmit unless continue bit set
// - index port selects register for data port
package nsc_pkg;
   // ==========================================================================
   // widths and register indices
   localparam int          NSC_DATA_W     = 16;
   localparam int          NSC_IDX_W      = 7;
   localparam logic [6:0]  NSC_IDX_CTRL   = 7'h00;  // controller_status_control
   localparam logic [6:0]  NSC_IDX_ADR_LO = 7'h01;  // init_block_addr_low
   localparam logic [6:0]  NSC_IDX_ADR_HI = 7'h02;  // init_block_addr_high
   localparam logic [6:0]  NSC_IDX_MASK   = 7'h03;  // interrupt_mask_deferral
   localparam logic [6:0]  NSC_IDX_SHD_LO = 7'h10;  // low address shadow
   localparam logic [6:0]  NSC_IDX_SHD_HI = 7'h11;  // high address shadow
   // ==========================================================================
   // control register bit positions
   localparam int NSC_B_INIT = 0;
   localparam int NSC_B_RUN  = 1;
   localparam int NSC_B_HALT = 2;
   localparam int NSC_B_POLL = 3;
   localparam int NSC_B_TX_ACTIVE = 4;
   localparam int NSC_B_RX_ACTIVE = 5;
   localparam int NSC_B_IRQ_MASTER_ENABLE = 6;
   localparam int NSC_B_IRQ_SUMMARY_FLAG = 7;
   localparam int NSC_B_INIT_DONE_FLAG = 8;
   localparam int NSC_B_TX_DONE_FLAG = 9;
   localparam int NSC_B_RX_DONE_FLAG = 10;
   localparam int NSC_B_ERR  = 15;
   localparam int NSC_B_UFC  = 6;                   // underflow_continue in mask reg
   // ==========================================================================
   // field groups and reset values
   localparam logic [15:0] NSC_W1C_BITS  = 16'h7F00;  // event flags 14..8
   localparam logic [15:0] NSC_IRQ_SRC   = 16'h5F00;  // flags able to interrupt
   localparam logic [15:0] NSC_ERR_SRC   = 16'h7800;  // flags feeding error bit
   localparam logic [15:0] NSC_MASK_BITS = 16'h5F40;  // writable mask-reg bits
   localparam logic [15:0] NSC_HI_BITS   = 16'h00FF;  // address bits 23:16
   localparam logic [15:0] NSC_LO_BITS   = 16'hFFFF;  // address bits 15:0
   localparam logic [15:0] NSC_MASK_RST  = 16'h0000;
   localparam logic [15:0] NSC_ZERO16    = 16'h0000;
   localparam logic [6:0]  NSC_IDX_RST   = 7'h00;
   // ==========================================================================
   // carriers
   typedef struct packed {
      logic        idx_wr;    // write index port
      logic        data_wr;   // write data port
      logic        data_rd;   // read data port
      logic [15:0] wdata;     // write data
   } nsc_bus_req_t;
   typedef struct packed {
      logic rx_frame_done;    // last rx descriptor handed back
      logic tx_frame_done;    // last tx descriptor handed back
      logic init_read_done;   // init block read finished
      logic tx_desc_fetch;    // buffer manager fetched tx descriptor
      logic tx_underflow;     // transmit underflow
      logic babble;           // babble error
      logic coll_err;         // collision error
      logic missed;           // missed frame
      logic mem_err;          // memory error
   } nsc_evt_t;
   typedef enum logic [1:0] {
      NSC_ST_STOP  = 2'b00,   // halted
      NSC_ST_INIT  = 2'b01,   // reading init block
      NSC_ST_READY = 2'b10,   // initialized, not running
      NSC_ST_RUN   = 2'b11    // running
   } nsc_state_t;
endpackage : nsc_pkg

// ### nsc_status_control_regs.sv
// module: status/control register bank with index/data port access
`timescale 1ns/100ps
module nsc_status_control_regs (
   input  wire logic                 clk,              // 200 MHz core clock
   input  wire logic                 rst_n,            // async reset, active low
   input  wire nsc_pkg::nsc_bus_req_t bus,             // index/data port request
   output logic [15:0]               rdata,            // data port read value
   input  wire nsc_pkg::nsc_evt_t    evt,              // buffer manager / mac events
   input  wire logic                 rx_disable,       // mode register receive off
   input  wire logic                 tx_disable,       // mode register transmit off
   input  wire logic                 suspend_bit,      // suspend state
   input  wire logic                 reset_reg_rd,     // read of reset register
   output logic                      irq,              // interrupt request, high
   output logic                      init_fetch_start, // pulse: read init block
   output logic                      run_enable,       // traffic and buffers enabled
   output logic                      rx_active,        // receive function on
   output logic                      tx_active,        // transmit function on
   output logic                      tx_ring_access,   // pulse: poll tx ring now
   output logic                      tx_resync,        // pulse: skip to next frame
   output logic [23:0]               init_block_pointer // init block address
);
   // ==========================================================================
   // state
   logic [6:0]          idx_reg, idx_next;          // selected register
   logic [15:0]         flag_reg, flag_next;        // sticky event flags
   logic [15:0]         mask_reg, mask_next;        // masks and underflow bit
   logic                halt_reg, halt_next;        // halt bit
   logic                run_reg, run_next;          // run request
   logic                init_reg, init_next;        // init request
   logic                irq_master_enable_reg, irq_master_enable_next;        // master enable
   logic                poll_reg, poll_next;        // transmit poll demand
   logic                rx_active_reg, rx_active_next;        // receive active
   logic                tx_active_reg, tx_active_next;        // transmit active
   logic                irq_summary_flag_reg, irq_summary_flag_next;        // summary flag
   logic                irq_reg, irq_next;          // interrupt output
   logic                fetch_reg, fetch_next;      // init fetch start pulse
   logic                kick_reg, kick_next;        // ring access pulse
   logic                resync_reg, resync_next;    // underflow resync pulse
   logic                run_en_reg, run_en_next;    // running state, output copy
   logic [15:0]         rdata_reg, rdata_next;      // read data
   logic [15:0]         adr_lo_reg, adr_lo_next;    // address low
   logic [15:0]         adr_hi_reg, adr_hi_next;    // address high
   logic [15:0]         shd_lo_reg, shd_lo_next;    // low shadow
   logic [15:0]         shd_hi_reg, shd_hi_next;    // high shadow
   nsc_pkg::nsc_state_t st_reg, st_next;            // sequencing state
   // ==========================================================================
   // decoded strobes
   logic        ctrl_wr;    // data write to control register
   logic        halt_wr;    // halt written as one
   logic        init_wr;    // init written, halt not
   logic        run_wr;     // run written, halt not
   logic        adr_open;   // address registers accessible
   logic [15:0] evt_vec;    // events in flag positions
   logic [15:0] clr_vec;    // software clear bits
   logic [15:0] ctrl_view;  // control register read image

   always_comb begin
      ctrl_wr  = bus.data_wr && (idx_reg == nsc_pkg::NSC_IDX_CTRL);
      halt_wr  = ctrl_wr && bus.wdata[nsc_pkg::NSC_B_HALT];
      init_wr  = ctrl_wr && bus.wdata[nsc_pkg::NSC_B_INIT] && !halt_wr;
      run_wr   = ctrl_wr && bus.wdata[nsc_pkg::NSC_B_RUN] && !halt_wr;
      adr_open = halt_reg || suspend_bit;
      evt_vec  = {1'b0, evt.babble, evt.coll_err, evt.missed, evt.mem_err,
                  evt.rx_frame_done, evt.tx_frame_done, evt.init_read_done, 8'h00};
      clr_vec  = ctrl_wr ? (bus.wdata & nsc_pkg::NSC_W1C_BITS) : nsc_pkg::NSC_ZERO16;
   end

   // ==========================================================================
   // run/halt sequencing and run-control bits
   always_comb begin
      st_next   = st_reg;
      halt_next = halt_reg;
      run_next  = run_reg;
      init_next = init_reg;
      fetch_next = 1'b0;
      if (halt_wr) begin                              // halt overrides run and init
         st_next   = nsc_pkg::NSC_ST_STOP;
         halt_next = 1'b1;
         run_next  = 1'b0;
         init_next = 1'b0;
      end else begin
         if (run_wr || init_wr) begin
            halt_next = 1'b0;
         end
         if (run_wr) begin
            run_next = 1'b1;
         end
         if (init_wr) begin
            init_next  = 1'b1;                        // stays set after fetch
            fetch_next = 1'b1;
            st_next    = nsc_pkg::NSC_ST_INIT;        // init first when both written
         end else begin
            unique case (st_reg)
               nsc_pkg::NSC_ST_INIT: begin
                  // run waits here until the block is in
                  if (evt.init_read_done) begin
                     st_next = (run_reg || run_wr) ? nsc_pkg::NSC_ST_RUN
                                                   : nsc_pkg::NSC_ST_READY;
                  end
               end
               nsc_pkg::NSC_ST_STOP, nsc_pkg::NSC_ST_READY: begin
                  if (run_wr) begin
                     st_next = nsc_pkg::NSC_ST_RUN;
                  end
               end
               nsc_pkg::NSC_ST_RUN: st_next = nsc_pkg::NSC_ST_RUN;
            endcase
         end
      end
      run_en_next = (st_next == nsc_pkg::NSC_ST_RUN);  // flop copy keeps output glitch free
   end

   // ==========================================================================
   // active bits, poll demand, underflow handling
   always_comb begin
      rx_active_next   = rx_active_reg;
      tx_active_next   = tx_active_reg;
      resync_next = 1'b0;
      if (halt_wr) begin
         rx_active_next = 1'b0;
         tx_active_next = 1'b0;
      end else if (st_next == nsc_pkg::NSC_ST_RUN && st_reg != nsc_pkg::NSC_ST_RUN) begin
         rx_active_next = !rx_disable;
         tx_active_next = !tx_disable;
      end else if (evt.tx_underflow && tx_active_reg) begin
         if (mask_reg[nsc_pkg::NSC_B_UFC]) begin
            resync_next = 1'b1;
         end else begin
            tx_active_next = 1'b0;
         end
      end
      // demand dropped while transmit is off, so no ring access follows
      poll_next = (poll_reg || (ctrl_wr && bus.wdata[nsc_pkg::NSC_B_POLL]))
                  && !evt.tx_desc_fetch && tx_active_reg && !halt_wr;
      // kick the ring once per demand edge; the manager answers with a fetch
      kick_next = poll_next && !poll_reg;
   end

   // ==========================================================================
   // event flags, masks, summary and interrupt
   always_comb begin
      // set beats clear; halt clears every flag, so a halt-cycle event is dropped
      flag_next = (evt_vec | (flag_reg & ~clr_vec)) & nsc_pkg::NSC_W1C_BITS;
      if (halt_wr) begin
         flag_next = nsc_pkg::NSC_ZERO16;
      end
      mask_next = mask_reg;
      if (bus.data_wr && idx_reg == nsc_pkg::NSC_IDX_MASK) begin
         mask_next = bus.wdata & nsc_pkg::NSC_MASK_BITS;
      end
      if (reset_reg_rd) begin
         mask_next[nsc_pkg::NSC_B_UFC] = 1'b0;
      end
      irq_master_enable_next = irq_master_enable_reg;
      if (halt_wr) begin
         irq_master_enable_next = 1'b0;
      end else if (ctrl_wr) begin
         irq_master_enable_next = bus.wdata[nsc_pkg::NSC_B_IRQ_MASTER_ENABLE];
      end
      // masks gate each interrupting flag; tx and init-done use bits 9 and 8
      irq_summary_flag_next = |(flag_next & nsc_pkg::NSC_IRQ_SRC & ~mask_next);
      irq_next  = irq_master_enable_next && irq_summary_flag_next;
   end

   // ==========================================================================
   // index port, address registers, read mux
   always_comb begin
      idx_next    = bus.idx_wr ? bus.wdata[6:0] : idx_reg;
      adr_lo_next = adr_lo_reg;
      adr_hi_next = adr_hi_reg;
      shd_lo_next = shd_lo_reg;
      shd_hi_next = shd_hi_reg;
      if (bus.data_wr && adr_open && idx_reg == nsc_pkg::NSC_IDX_ADR_LO) begin
         adr_lo_next = bus.wdata & nsc_pkg::NSC_LO_BITS;
         shd_lo_next = bus.wdata & nsc_pkg::NSC_LO_BITS;
      end
      if (bus.data_wr && adr_open && idx_reg == nsc_pkg::NSC_IDX_ADR_HI) begin
         adr_hi_next = bus.wdata & nsc_pkg::NSC_HI_BITS;
         shd_hi_next = bus.wdata & nsc_pkg::NSC_HI_BITS;
      end
      ctrl_view = flag_reg;
      ctrl_view[nsc_pkg::NSC_B_ERR]  = |(flag_reg & nsc_pkg::NSC_ERR_SRC);
      ctrl_view[nsc_pkg::NSC_B_IRQ_SUMMARY_FLAG] = irq_summary_flag_reg;
      ctrl_view[nsc_pkg::NSC_B_IRQ_MASTER_ENABLE] = irq_master_enable_reg;
      ctrl_view[nsc_pkg::NSC_B_RX_ACTIVE] = rx_active_reg;
      ctrl_view[nsc_pkg::NSC_B_TX_ACTIVE] = tx_active_reg;
      ctrl_view[nsc_pkg::NSC_B_POLL] = poll_reg;
      ctrl_view[nsc_pkg::NSC_B_HALT] = halt_reg;
      ctrl_view[nsc_pkg::NSC_B_RUN]  = run_reg;
      ctrl_view[nsc_pkg::NSC_B_INIT] = init_reg;
      rdata_next = rdata_reg;
      if (bus.data_rd) begin
         unique case (idx_reg)
            nsc_pkg::NSC_IDX_CTRL:   rdata_next = ctrl_view;
            nsc_pkg::NSC_IDX_ADR_LO: rdata_next = adr_open ? adr_lo_reg : nsc_pkg::NSC_ZERO16;
            nsc_pkg::NSC_IDX_ADR_HI: rdata_next = adr_open ? adr_hi_reg : nsc_pkg::NSC_ZERO16;
            nsc_pkg::NSC_IDX_MASK:   rdata_next = mask_reg;
            nsc_pkg::NSC_IDX_SHD_LO: rdata_next = shd_lo_reg;
            nsc_pkg::NSC_IDX_SHD_HI: rdata_next = shd_hi_reg;
            default:                 rdata_next = nsc_pkg::NSC_ZERO16;  // unmapped
         endcase
      end
   end

   // ==========================================================================
   // control registers; reset puts the bank in halt
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg     <= nsc_pkg::NSC_ST_STOP;
         idx_reg    <= nsc_pkg::NSC_IDX_RST;
         flag_reg   <= nsc_pkg::NSC_ZERO16;
         mask_reg   <= nsc_pkg::NSC_MASK_RST;
         halt_reg   <= 1'b1;
         run_reg    <= 1'b0;
         init_reg   <= 1'b0;
         irq_master_enable_reg   <= 1'b0;
         poll_reg   <= 1'b0;
         rx_active_reg   <= 1'b0;
         tx_active_reg   <= 1'b0;
         irq_summary_flag_reg   <= 1'b0;
         irq_reg    <= 1'b0;
         fetch_reg  <= 1'b0;
         kick_reg   <= 1'b0;
         resync_reg <= 1'b0;
         run_en_reg <= 1'b0;
         rdata_reg  <= nsc_pkg::NSC_ZERO16;
      end else begin
         st_reg     <= st_next;
         idx_reg    <= idx_next;
         flag_reg   <= flag_next;
         mask_reg   <= mask_next;
         halt_reg   <= halt_next;
         run_reg    <= run_next;
         init_reg   <= init_next;
         irq_master_enable_reg   <= irq_master_enable_next;
         poll_reg   <= poll_next;
         rx_active_reg   <= rx_active_next;
         tx_active_reg   <= tx_active_next;
         irq_summary_flag_reg   <= irq_summary_flag_next;
         irq_reg    <= irq_next;
         fetch_reg  <= fetch_next;
         kick_reg   <= kick_next;
         resync_reg <= resync_next;
         run_en_reg <= run_en_next;
         rdata_reg  <= rdata_next;
      end
   end

   // address registers keep their contents across reset, so no reset term
   always_ff @(posedge clk) begin
      adr_lo_reg <= adr_lo_next;
      adr_hi_reg <= adr_hi_next;
      shd_lo_reg <= shd_lo_next;
      shd_hi_reg <= shd_hi_next;
   end

   // ==========================================================================
   // outputs, all straight from flops
   assign rdata              = rdata_reg;
   assign irq                = irq_reg;
   assign init_fetch_start   = fetch_reg;
   assign run_enable         = run_en_reg;
   assign rx_active          = rx_active_reg;
   assign tx_active          = tx_active_reg;
   assign tx_ring_access     = kick_reg;
   assign tx_resync          = resync_reg;
   assign init_block_pointer = {adr_hi_reg[7:0], adr_lo_reg};

   // ==========================================================================
   // assertions
   property p_rx_set;
      @(posedge clk) disable iff (!rst_n)
      evt.rx_frame_done && !halt_wr |=> flag_reg[nsc_pkg::NSC_B_RX_DONE_FLAG];
   endproperty
   a_rx_set: assert property (p_rx_set) else $error("rx flag not set");

   property p_w1c;
      @(posedge clk) disable iff (!rst_n)
      ctrl_wr && bus.wdata[nsc_pkg::NSC_B_RX_DONE_FLAG] && !evt.rx_frame_done
      |=> !flag_reg[nsc_pkg::NSC_B_RX_DONE_FLAG];
   endproperty
   a_w1c: assert property (p_w1c) else $error("rx flag not cleared");

   property p_set_wins;
      @(posedge clk) disable iff (!rst_n)
      evt.tx_frame_done && ctrl_wr && bus.wdata[nsc_pkg::NSC_B_TX_DONE_FLAG] && !halt_wr
      |=> flag_reg[nsc_pkg::NSC_B_TX_DONE_FLAG];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat set");

   property p_summary;
      @(posedge clk) disable iff (!rst_n)
      irq_summary_flag_reg == |(flag_reg & nsc_pkg::NSC_IRQ_SRC & ~mask_reg);
   endproperty
   a_summary: assert property (p_summary) else $error("summary mismatch");

   property p_irq;
      @(posedge clk) disable iff (!rst_n)
      irq_reg == (irq_master_enable_reg && irq_summary_flag_reg);
   endproperty
   a_irq: assert property (p_irq) else $error("irq gating wrong");

   property p_halt_prio;
      @(posedge clk) disable iff (!rst_n)
      ctrl_wr && (bus.wdata[2:0] == 3'h7) |=> halt_reg && !run_reg && !init_reg && !rx_active_reg;
   endproperty
   a_halt_prio: assert property (p_halt_prio) else $error("halt lost priority");

   property p_init_wait;
      @(posedge clk) disable iff (!rst_n)
      st_reg == nsc_pkg::NSC_ST_INIT && !evt.init_read_done && !run_wr && !rx_active_reg && !tx_active_reg
      |=> !rx_active_reg && !tx_active_reg;
   endproperty
   a_init_wait: assert property (p_init_wait) else $error("active before init");

   property p_poll_drop;
      @(posedge clk) disable iff (!rst_n)
      !tx_active_reg |=> !poll_reg && !kick_reg;
   endproperty
   a_poll_drop: assert property (p_poll_drop) else $error("demand kept while off");

   property p_addr_lock;
      @(posedge clk) disable iff (!rst_n)
      bus.data_wr && !adr_open |=> $stable(adr_lo_reg) && $stable(adr_hi_reg);
   endproperty
   a_addr_lock: assert property (p_addr_lock) else $error("address written");

   property p_tx_underflow;
      @(posedge clk) disable iff (!rst_n)
      evt.tx_underflow && tx_active_reg && !mask_reg[nsc_pkg::NSC_B_UFC]
      && !init_wr && !run_wr && !evt.init_read_done |=> !tx_active_reg;
   endproperty
   a_tx_underflow: assert property (p_tx_underflow) else $error("underflow kept tx on");

   c_init_run: cover property (@(posedge clk) disable iff (!rst_n)
      st_reg == nsc_pkg::NSC_ST_INIT ##[1:20] st_reg == nsc_pkg::NSC_ST_RUN);
   c_irq: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq_reg));
   c_resync: cover property (@(posedge clk) disable iff (!rst_n) resync_reg);
endmodule : nsc_status_control_regs

// ### tb_nsc_status_control_regs.sv
// testbench: self-checking bench for the status/control register bank
`timescale 1ns/100ps
module tb_nsc_status_control_regs;
   // ==========================================================================
   // stimulus and model state
   logic                  clk = 1'b0;          // 200 MHz core clock
   logic                  rst_n = 1'b0;        // async reset, active low
   nsc_pkg::nsc_bus_req_t bus = '0;            // index/data port request
   nsc_pkg::nsc_evt_t     evt = '0;            // event pulses
   logic                  rx_dis = 1'b0;       // receive disable level
   logic                  tx_dis = 1'b0;       // transmit disable level
   logic                  susp = 1'b0;         // suspend level
   logic                  rst_rd = 1'b0;       // reset register read pulse
   logic [15:0]           rdata;               // read data seen
   logic                  irq, fetch, run_en, rxa, txa, ring, resync;
   logic [23:0]           ptr;                 // init block pointer seen
   logic [15:0]           m_base, m_flags, m_mask, lo, hi;  // model image parts
   logic [31:0]           lfsr = 32'h3B5072BD; // random state, fixed seed
   int                    num_errors = 0;      // mismatches
   int                    n_compared = 0;      // comparisons
   int                    cycles = 0;          // hang guard
   int                    n_ring = 0;          // ring access pulses seen
   int                    n_fetch = 0;         // init fetch pulses seen
   int                    n_resync = 0;        // resync pulses seen
   always #2.5 clk = ~clk;
   nsc_status_control_regs dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .evt(evt),
      .rx_disable(rx_dis), .tx_disable(tx_dis), .suspend_bit(susp), .reset_reg_rd(rst_rd),
      .irq(irq), .init_fetch_start(fetch), .run_enable(run_en), .rx_active(rxa),
      .tx_active(txa), .tx_ring_access(ring), .tx_resync(resync), .init_block_pointer(ptr));
   // ==========================================================================
   // helpers
   function automatic logic [31:0] next_rand();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction : next_rand
   task automatic complete_run();
      if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : complete_run
   task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // one request held over one edge, then an idle cycle
   task automatic op(input logic i, input logic w, input logic r, input logic [15:0] d);
      bus = '{idx_wr: i, data_wr: w, data_rd: r, wdata: d};
      @(posedge clk); #1 bus = '0;
      @(posedge clk); #1;
   endtask : op
   task automatic wr(input logic [15:0] idx, input logic [15:0] d);
      op(1'b1, 1'b0, 1'b0, idx);
      op(1'b0, 1'b1, 1'b0, d);
   endtask : wr
   task automatic rd_chk(input logic [15:0] idx, input logic [15:0] exp);
      op(1'b1, 1'b0, 1'b0, idx);
      op(1'b0, 1'b0, 1'b1, 16'h0000);
      chk("rdata", {8'h00, rdata}, {8'h00, exp});
   endtask : rd_chk
   task automatic pulse(input logic [8:0] e);
      evt = nsc_pkg::nsc_evt_t'(e);
      @(posedge clk); #1 evt = '0;
      @(posedge clk); #1;
   endtask : pulse
   // model image: summary is the or of unmasked flags other than collision
   task automatic check_ctrl();
      logic irq_summary_flag;
      irq_summary_flag = |(m_flags & nsc_pkg::NSC_IRQ_SRC & ~m_mask);
      rd_chk(16'h0000, m_base | m_flags | {8'h00, irq_summary_flag, 7'h00});
      chk("irq", {23'h0, irq}, {23'h0, m_base[6] & irq_summary_flag});
      chk("rx_active", {23'h0, rxa}, {23'h0, m_base[5]});
      chk("tx_active", {23'h0, txa}, {23'h0, m_base[4]});
   endtask : check_ctrl
   // ==========================================================================
   // hang guard; one-cycle output pulses are counted as they stand
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (ring) n_ring <= n_ring + 1;
      if (fetch) n_fetch <= n_fetch + 1;
      if (resync) n_resync <= n_resync + 1;
      if (cycles == 4000) begin
         num_errors++;
         complete_run();
      end
   end
   // ==========================================================================
   // main sequence
   initial begin
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      m_base = 16'h0004; m_flags = '0; m_mask = '0;
      check_ctrl();
      rd_chk(16'h0003, 16'h0000);
      lo = next_rand() & 16'hFFFE; hi = {8'h00, next_rand() & 8'hFF};
      wr(16'h0001, lo); wr(16'h0002, hi);
      rd_chk(16'h0001, lo);
      rd_chk(16'h0010, lo);
      rd_chk(16'h0011, hi);
      chk("pointer", ptr, {hi[7:0], lo});
      wr(16'h0000, 16'h0042); m_base = 16'h0072;
      check_ctrl();
      chk("run_enable", {23'h0, run_en}, 24'h1);
      wr(16'h0001, ~lo);
      rd_chk(16'h0001, 16'h0000);
      chk("pointer", ptr, {hi[7:0], lo});
      // each done flag: set, masked, cleared by writing one
      for (int i = 0; i < 3; i++) begin
         pulse(9'h100 >> i); m_flags = 16'h0400 >> i;
         check_ctrl();
         wr(16'h0003, m_flags); m_mask = m_flags;
         check_ctrl();
         wr(16'h0003, 16'h0000); m_mask = '0;
         wr(16'h0000, 16'h0040 | m_flags); m_flags = '0;
         check_ctrl();
      end
      pulse(9'h100); m_flags = 16'h0400;
      wr(16'h0000, 16'h0000); m_base = 16'h0032;
      check_ctrl();
      wr(16'h0000, 16'h0400); m_flags = '0;
      wr(16'h0000, 16'h0008);
      chk("ring", 24'(n_ring), 24'h1);
      m_base = 16'h003A;
      check_ctrl();
      pulse(9'h020); m_base = 16'h0032;
      check_ctrl();
      pulse(9'h010); m_base = 16'h0022;
      check_ctrl();
      wr(16'h0000, 16'h0007); m_base = 16'h0004;
      check_ctrl();
      chk("run_enable", {23'h0, run_en}, 24'h0);
      chk("fetch", 24'(n_fetch), 24'h0);
      wr(16'h0000, 16'h0003); m_base = 16'h0003;
      check_ctrl();
      chk("fetch", 24'(n_fetch), 24'h1);
      pulse(9'h040); m_base = 16'h0033; m_flags = 16'h0100;
      check_ctrl();
      // underflow with the continue bit set resyncs and keeps transmit on
      wr(16'h0003, 16'h0040); m_mask = 16'h0040;
      pulse(9'h010);
      chk("resync", 24'(n_resync), 24'h1);
      check_ctrl();
      rst_rd = 1'b1;
      @(posedge clk); #1 rst_rd = 1'b0;
      rd_chk(16'h0003, 16'h0000);
      m_mask = '0;
      // second reset in mid-run: bank halts, address keeps its contents
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      m_base = 16'h0004; m_flags = '0;
      check_ctrl();
      chk("pointer", ptr, {hi[7:0], lo});
      chk("run_enable", {23'h0, run_en}, 24'h0);
      rd_chk(16'h0010, lo);
      complete_run();
   end
endmodule : tb_nsc_status_control_regs
